// >>> hdl/dram_mode_cfg.svh
`ifndef DRAM_MODE_CFG_SVH
`define DRAM_MODE_CFG_SVH

// Command encodings on {cs_n, ras_n, cas_n, we_n}
`define CMD_MODE_SET      4'h0
`define CMD_REFRESH       4'h1
`define CMD_PRECHARGE     4'h2
`define CMD_ACTIVE        4'h3
`define CMD_WRITE         4'h4
`define CMD_READ          4'h5
`define CMD_NOP           4'h7
// Bank address selecting the target of a mode set
`define BANK_MAIN_MODE    2'h0
`define BANK_EXT1         2'h1
`define BANK_EXT2         2'h2
`define BANK_EXT3         2'h3
// Main mode register fields
`define MODE_BL_LSB       0
`define MODE_BT_BIT       3
`define MODE_CL_LSB       4
`define MODE_TM_BIT       7
`define MODE_DLL_RST_BIT  8
`define MODE_WR_LSB       9
`define BL_CODE_4         3'h2
`define BL_CODE_8         3'h3
// Extended register 1 fields
`define EXT1_DLL_OFF_BIT  0
`define EXT1_CAL_LSB      7
`define CAL_DEFAULT       3'h7
`define CAL_EXIT          3'h0
// Address bit 10: auto precharge on read/write, all banks on precharge
`define AUTO_PRE_BIT      10
`define PRE_ALL_BIT       10
// Timing and reset value
`define DLL_LOCK_CLOCKS   200
`define MODE_RESET_VALUE  16'h0000

`endif

// >>> hdl/dram_mode_pkg.sv
package dram_mode_pkg;
   typedef enum logic [2:0] {
      ST_POWER  = 3'b000,
      ST_IDLE   = 3'b001,
      ST_ACTIVE = 3'b010
   } bank_state_t;
   typedef logic [15:0] mode_word_t;
endpackage : dram_mode_pkg

// >>> hdl/dram_mode_ctrl.sv
`timescale 1ns/1ps
`include "dram_mode_cfg.svh"
// Operation
// - Active picks bank and row first
// - Read/write address gives column, auto precharge
// - Main mode register undefined until written
// - Mode write: all low, banks precharged
// - Mode rewrite allowed when all precharged
// - Mode writes leave array data intact
// - Burst length, ordering, read latency fields
// - Test bit, loop reset, write recovery
module dram_mode_ctrl
   import dram_mode_pkg::*;
#(
   parameter int BANKS = 4,
   parameter int ROW_W = 13,
   parameter int COL_W = 10
)(
   input  wire logic                 clock,
   input  wire logic                 rstn,
   input  wire logic                 clk_en,
   input  wire logic                 cke,
   input  wire logic                 cs_n,
   input  wire logic                 ras_n,
   input  wire logic                 cas_n,
   input  wire logic                 we_n,
   input  wire logic [1:0]           bank_addr,
   input  wire logic [15:0]          addr,
   output logic [15:0]               operating_mode_register,
   output logic [15:0]               ext1_mode,
   output logic                      mode_valid,
   output logic                      dll_locked,
   output logic                      cal_default,
   output logic [2:0]                burst_len,
   output logic                      burst_interleave,
   output logic [2:0]                read_latency,
   output logic [2:0]                write_recovery_time,
   output logic                      test_mode,
   output logic                      access_go,
   output logic                      access_write,
   output logic [1:0]                access_bank,
   output logic [ROW_W-1:0]          access_row,
   output logic [COL_W-1:0]          access_col,
   output logic                      access_auto_pre,
   output logic                      cmd_refused
);
   import dram_mode_pkg::*;

   localparam int LOCK_W = $clog2(`DLL_LOCK_CLOCKS + 1);

   logic [3:0]        cmd;
   logic              all_idle;
   logic [BANKS-1:0]  open_reg;
   logic [ROW_W-1:0]  row_reg [BANKS];
   logic [LOCK_W-1:0] lock_cnt_reg;
   logic              cke_reg;
   logic              fire;
   logic              mode_take;
   logic              dll_reset_take;
   logic              dll_reset_seen_reg;

   // Read and write share one decode, used by launch and bank tracking
   function automatic logic is_access(input logic [3:0] code);
      return (code == `CMD_READ) || (code == `CMD_WRITE);
   endfunction : is_access

   // Deselect reads as NOP; decode needs cke high on two enabled edges
   assign cmd      = cs_n ? `CMD_NOP : {1'b0, ras_n, cas_n, we_n};
   assign fire     = clk_en && cke && cke_reg;
   assign all_idle = (open_reg == '0);
   // A mode set while a bank is open is refused, never half applied
   assign mode_take      = fire && (cmd == `CMD_MODE_SET) && all_idle;
   assign dll_reset_take = mode_take && (bank_addr == `BANK_MAIN_MODE) &&
                           addr[`MODE_DLL_RST_BIT];

   ////////////////////////////////////////////////////////////////////////
   // CKE registration; power-down freezes command decode
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         cke_reg <= 1'b0;
      else if (clk_en)
         cke_reg <= cke;
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode register writes; array contents are never touched here
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         operating_mode_register <= `MODE_RESET_VALUE;
         ext1_mode               <= `MODE_RESET_VALUE;
         mode_valid              <= 1'b0;
      end
      else if (mode_take)
      begin
         if (bank_addr == `BANK_MAIN_MODE)
         begin
            operating_mode_register <= addr;
            mode_valid              <= 1'b1;
         end
         else if (bank_addr == `BANK_EXT1)
            ext1_mode <= addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Field views of the main mode register and of extended register 1
   assign burst_len        = operating_mode_register[`MODE_BL_LSB +: 3];
   assign burst_interleave = operating_mode_register[`MODE_BT_BIT];
   assign read_latency     = operating_mode_register[`MODE_CL_LSB +: 3];
   assign test_mode        = operating_mode_register[`MODE_TM_BIT];
   assign write_recovery_time =
      operating_mode_register[`MODE_WR_LSB +: 3];
   assign cal_default =
      (ext1_mode[`EXT1_CAL_LSB +: 3] == `CAL_DEFAULT);

   ////////////////////////////////////////////////////////////////////////
   // Delay loop lock counter; a loop reset restarts the wait
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         lock_cnt_reg <= '0;
      else if (clk_en)
      begin
         if (dll_reset_take)
            lock_cnt_reg <= LOCK_W'(`DLL_LOCK_CLOCKS);
         else if (lock_cnt_reg != '0)
            lock_cnt_reg <= lock_cnt_reg - 1'b1;
      end
   end
   // Loop reset seen once; a main write without A8 must not claim lock
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         dll_reset_seen_reg <= 1'b0;
      else if (dll_reset_take)
         dll_reset_seen_reg <= 1'b1;
   end

   // Lock needs a loop reset seen at least once and the loop enabled
   assign dll_locked = dll_reset_seen_reg && mode_valid &&
                       (lock_cnt_reg == '0) &&
                       !ext1_mode[`EXT1_DLL_OFF_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Bank open tracking with stored row per bank
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         open_reg <= '0;
      else if (fire)
      begin
         if (cmd == `CMD_ACTIVE)
            open_reg[bank_addr] <= 1'b1;
         else if (cmd == `CMD_PRECHARGE)
         begin
            if (addr[`PRE_ALL_BIT])
               open_reg <= '0;
            else
               open_reg[bank_addr] <= 1'b0;
         end
         else if (is_access(cmd) && addr[`AUTO_PRE_BIT] &&
                  open_reg[bank_addr])
            open_reg[bank_addr] <= 1'b0;
      end
   end

   // Row storage carries no reset; it is data, not control
   always_ff @(posedge clock)
   begin
      if (fire && cmd == `CMD_ACTIVE)
         row_reg[bank_addr] <= addr[ROW_W-1:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Access launch: column and auto precharge from read/write address
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         access_go       <= 1'b0;
         access_write    <= 1'b0;
         access_bank     <= 2'h0;
         access_row      <= '0;
         access_col      <= '0;
         access_auto_pre <= 1'b0;
         cmd_refused     <= 1'b0;
      end
      else if (clk_en)
      begin
         access_go   <= 1'b0;
         cmd_refused <= 1'b0;
         if (fire && is_access(cmd))
         begin
            if (open_reg[bank_addr])
            begin
               access_go       <= 1'b1;
               access_write    <= (cmd == `CMD_WRITE);
               access_bank     <= bank_addr;
               access_row      <= row_reg[bank_addr];
               access_col      <= addr[COL_W-1:0];
               access_auto_pre <= addr[`AUTO_PRE_BIT];
            end
            else
               cmd_refused <= 1'b1;
         end
         else if (fire && cmd == `CMD_MODE_SET && !all_idle)
            cmd_refused <= 1'b1;
      end
   end
endmodule : dram_mode_ctrl

// >>> bench/mode_cfg_chk.sv
`timescale 1ns/1ps
`include "dram_mode_cfg.svh"
module mode_cfg_chk
(
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        clk_en,
   input wire logic        cke,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [1:0]  bank_addr,
   input wire logic [15:0] addr,
   input wire logic [15:0] operating_mode_register,
   input wire logic [15:0] ext1_mode,
   input wire logic        mode_valid,
   input wire logic        dll_locked,
   input wire logic        cal_default,
   input wire logic [2:0]  burst_len,
   input wire logic [2:0]  read_latency,
   input wire logic [2:0]  write_recovery_time,
   input wire logic        access_go,
   input wire logic        access_write,
   input wire logic        access_auto_pre,
   input wire logic [1:0]  access_bank,
   input wire logic [9:0]  access_col,
   input wire logic        cmd_refused
);
   // Device only decodes once cke was high on the previous enabled edge
   logic ck_q;
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) ck_q <= 1'b0;
      else if (clk_en) ck_q <= cke;
   wire logic       tk = clk_en & cke & ck_q & !cs_n;
   wire logic [3:0] c  = {cs_n, ras_n, cas_n, we_n};
   wire logic       ms = tk && c == `CMD_MODE_SET;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   main_write_a: assert property (ms && bank_addr == 2'h0 |=>
      cmd_refused || operating_mode_register == $past(addr))
      else $error("main mode write lost");
   ext1_write_a: assert property (ms && bank_addr == 2'h1 |=>
      cmd_refused || ext1_mode == $past(addr)) else $error("ext1 write lost");
   field_view_a: assert property (burst_len == operating_mode_register[2:0]
      && read_latency == operating_mode_register[6:4]
      && write_recovery_time == operating_mode_register[11:9])
      else $error("mode fields wrong");
   cal_flag_a: assert property (cal_default == (ext1_mode[9:7] == 3'h7))
      else $error("calibration flag wrong");
   lock_wait_a: assert property (ms && bank_addr == 2'h0 && addr[8]
      ##1 !cmd_refused |-> !dll_locked [*7]) else $error("lock too early");
   one_answer_a: assert property (tk && (c == `CMD_READ || c == `CMD_WRITE)
      |=> access_go != cmd_refused) else $error("access answer wrong");
   access_take_a: assert property (access_go |->
      access_col == $past(addr[9:0]) && access_auto_pre == $past(addr[10])
      && access_bank == $past(bank_addr) && access_write == !$past(we_n))
      else $error("access fields wrong");
   no_cause_a: assert property (!tk |=> !access_go && !cmd_refused)
      else $error("answer without command");
   valid_set_a: assert property ($rose(mode_valid) |->
      $past(ms && bank_addr == 2'h0)) else $error("valid without write");
   cover property (access_go && access_write);
   cover property (cmd_refused);
   cover property ($rose(dll_locked));
endmodule : mode_cfg_chk
////////////////////////////////////////////////////////////////////////////
bind dram_mode_ctrl mode_cfg_chk chk_u (.clock(clock), .rstn(rstn),
   .clk_en(clk_en), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
   .we_n(we_n), .bank_addr(bank_addr), .addr(addr),
   .operating_mode_register(operating_mode_register),
   .ext1_mode(ext1_mode), .mode_valid(mode_valid), .dll_locked(dll_locked),
   .cal_default(cal_default), .burst_len(burst_len),
   .read_latency(read_latency), .write_recovery_time(write_recovery_time),
   .access_go(access_go), .access_write(access_write),
   .access_auto_pre(access_auto_pre), .access_bank(access_bank),
   .access_col(access_col), .cmd_refused(cmd_refused));

// >>> bench/ctrl_model.sv
`timescale 1ns/1ps
`include "dram_mode_cfg.svh"
module ctrl_model
(
   input  wire logic  clock,
   output logic       cke,
   output logic [3:0] cmd,
   output logic [1:0] bank_addr,
   output logic [15:0] addr
);
   initial
   begin
      cke = 1'b0;
      cmd = `CMD_NOP;
      bank_addr = 2'h0;
      addr = 16'h0000;
   end
   // A NOP after every command spaces writes from reads and mode sets
   task automatic issue(input logic [3:0] c, input logic [1:0] b,
                        input logic [15:0] a);
   begin
      #1 cmd = c; bank_addr = b; addr = a;
      @(posedge clock);
      #1 cmd = `CMD_NOP; bank_addr = ~b; addr = ~a;
      @(posedge clock);
   end
   endtask : issue
   task automatic init_seq(input logic [15:0] m);
   begin
      cke = 1'b0;
      repeat (4000) @(posedge clock);
      #1 cke = 1'b1;
      repeat (8) @(posedge clock);
      issue(`CMD_PRECHARGE, 2'h0, 16'h0400);
      issue(`CMD_MODE_SET, `BANK_EXT2, 16'h0000);
      issue(`CMD_MODE_SET, `BANK_EXT3, 16'h0000);
      issue(`CMD_MODE_SET, `BANK_EXT1, 16'h0000);
      issue(`CMD_MODE_SET, `BANK_MAIN_MODE, m | 16'h0100);
      issue(`CMD_PRECHARGE, 2'h0, 16'h0400);
      repeat (2) issue(`CMD_REFRESH, 2'h0, 16'h0000);
      issue(`CMD_MODE_SET, `BANK_MAIN_MODE, m);
      // Calibration default only once the loop lock time has passed
      repeat (200) @(posedge clock);
      issue(`CMD_MODE_SET, `BANK_EXT1, 16'h0380);
   end
   endtask : init_seq
endmodule : ctrl_model

// >>> bench/ddr2_init_and_mode_register_test.sv
`timescale 1ns/1ps
`include "dram_mode_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module ddr2_init_and_mode_register_test;
   import dram_mode_pkg::*;
   logic clock = 0, rstn = 0, clk_en = 1, cke, mv, dl, cd, go, aw, ap, rf;
   logic bi, tm, w, p;
   logic [3:0] cmd;
   logic [1:0] ba, ab, b;
   logic [15:0] addr;
   mode_word_t omr, e1;
   logic [2:0] bl, rl, wr;
   logic [12:0] ar, r;
   logic [9:0] ac, cl;
   logic [31:0] rv;
   logic [27:0] q[$];
   logic [27:0] e;
   int miscompares = 0, n_checks = 0, seed = 75241, cyc = 0;
   always #25 clock = ~clock;
   ctrl_model ctrl_u (.clock(clock), .cke(cke), .cmd(cmd), .bank_addr(ba),
      .addr(addr));
   dram_mode_ctrl dut_u (.clock(clock), .rstn(rstn), .clk_en(clk_en),
      .cke(cke), .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]),
      .we_n(cmd[0]), .bank_addr(ba), .addr(addr),
      .operating_mode_register(omr), .ext1_mode(e1), .mode_valid(mv),
      .dll_locked(dl), .cal_default(cd), .burst_len(bl),
      .burst_interleave(bi), .read_latency(rl), .write_recovery_time(wr),
      .test_mode(tm), .access_go(go), .access_write(aw), .access_bank(ab),
      .access_row(ar), .access_col(ac), .access_auto_pre(ap),
      .cmd_refused(rf));
   task automatic close_out;
   begin
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   end
   endtask : close_out
   // Hang guard: the run needs about 4500 cycles
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000) begin miscompares++; close_out(); end
   end
   // Each answer pulse consumes the oldest expected note
   always @(posedge clock) #2 if (go === 1'b1 || rf === 1'b1)
   begin
      e = q.pop_front();
      `CHK(rf, e[27])
      if (!e[27]) `CHK({ap, aw, ab, ar, ac}, e[26:0])
   end
   initial
   begin
      repeat (5) @(posedge clock);
      #1 rstn = 1'b1;
      `CHK({mv, dl}, 2'b00)
      ctrl_u.init_seq(16'h064b);
      `CHK({mv, omr}, {1'b1, 16'h064b})
      `CHK({bl, bi, rl, tm, wr}, {3'h3, 1'b1, 3'h4, 1'b0, 3'h3})
      `CHK({cd, dl}, 2'b11)
      `CHK(e1, 16'h0380)
      ctrl_u.issue(`CMD_MODE_SET, `BANK_EXT1, 16'h0000);
      `CHK(cd, 1'b0)
      // Reinitialising the loop mid-run restarts the 200 clock wait
      ctrl_u.issue(`CMD_MODE_SET, `BANK_MAIN_MODE, 16'h074b);
      `CHK({omr, dl}, {16'h074b, 1'b0})
      repeat (198) @(posedge clock);
      `CHK(dl, 1'b0)
      repeat (2) @(posedge clock);
      `CHK(dl, 1'b1)
      #1 clk_en = 1'b0;
      ctrl_u.issue(`CMD_MODE_SET, `BANK_MAIN_MODE, 16'h0242);
      `CHK(omr, 16'h074b)
      #1 clk_en = 1'b1;
      ctrl_u.issue(`CMD_MODE_SET, `BANK_MAIN_MODE, 16'h0432);
      `CHK({omr, bl, bi}, {16'h0432, 3'h2, 1'b0})
      repeat (12)
      begin
         rv = $random(seed);
         {p, w, cl, r, b} = rv[26:0];
         ctrl_u.issue(`CMD_ACTIVE, b, {3'h0, r});
         q.push_back({1'b0, p, w, b, r, cl});
         ctrl_u.issue(w ? `CMD_WRITE : `CMD_READ, b, {5'h0, p, cl});
         if (!p) ctrl_u.issue(`CMD_PRECHARGE, b, 16'h0000);
      end
      q.push_back(28'h8000000);
      ctrl_u.issue(`CMD_READ, 2'h1, 16'h0000);
      ctrl_u.issue(`CMD_ACTIVE, 2'h2, 16'h0011);
      q.push_back(28'h8000000);
      ctrl_u.issue(`CMD_MODE_SET, `BANK_MAIN_MODE, 16'h0000);
      `CHK(omr, 16'h0432)
      ctrl_u.issue(`CMD_PRECHARGE, 2'h0, 16'h0400);
      `CHK(q.size(), 0)
      close_out();
   end
endmodule : ddr2_init_and_mode_register_test
